// >>> logic/bist_dram_pkg.sv
// Shared constants and types of the DRAM and concurrent-port cycle signal generator
package bist_dram_pkg;

  // Per-cycle controlled signals, one resolved level each
  localparam int NSIG     = 7;
  localparam int NDRAM    = 5;
  localparam int SIG_ACT  = 0;
  localparam int SIG_PRE  = 1;
  localparam int SIG_CAS  = 2;
  localparam int SIG_RAS  = 3;
  localparam int SIG_REF  = 4;
  localparam int SIG_CRD  = 5;
  localparam int SIG_ASEL = 6;
  localparam int CODE_W   = 2 * NSIG;

  // Per-signal program code of one operation cycle
  typedef enum logic [1:0] {
    CODE_AUTO = 2'b00,
    CODE_OFF  = 2'b01,
    CODE_ON   = 2'b10
  } cycle_code_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } op_state_t;

  // APB map
  localparam int          APB_AW      = 8;
  localparam logic [7:0]  CTRL_OFFS   = 8'h00;
  localparam logic [7:0]  STATUS_OFFS = 8'h04;
  localparam logic [7:0]  PROG_BASE   = 8'h10;

  // Configuration register fields
  localparam int          POL_LSB     = 0;
  localparam int          PRESENT_LSB = 8;
  localparam int          MUX_BIT     = 16;
  localparam int          HASROW_BIT  = 17;
  localparam int          HASCOL_BIT  = 18;
  localparam int          CONCCAP_BIT = 19;
  localparam int          CMPEN_BIT   = 20;
  localparam int          SYNCRD_BIT  = 21;
  localparam int          PORTSEL_BIT = 24;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_001F;

  // Status register fields
  localparam int          STAT_HELD_LSB = 0;
  localparam int          STAT_RUN_BIT  = 8;

endpackage

// >>> logic/cycle_code_resolver.sv
// Resolution of on, off and auto codes into held signal levels
`timescale 1ns/100ps
`default_nettype none

module cycle_code_resolver #(
  parameter int NSIG = 7
) (
  // Program codes of the current cycle, two bits per signal
  input  wire logic [2*NSIG-1:0] codes,
  // Levels held from the previous cycle of the operation
  input  wire logic [NSIG-1:0]   held,
  input  wire logic              firstCycle,
  // Resolved levels for this cycle
  output logic      [NSIG-1:0]   nextHeld
);
  import bist_dram_pkg::*;

  genvar g;
  generate
    for (g = 0; g < NSIG; g++) begin : gSig
      // Code 2'b11 is unused and behaves as auto
      assign nextHeld[g] = (codes[2*g +: 2] == CODE_ON)  ? 1'b1 :
                           (codes[2*g +: 2] == CODE_OFF) ? 1'b0 :
                           (firstCycle ? 1'b0 : held[g]); // RULE_02 RULE_13
    end
  endgenerate

endmodule
`default_nettype wire

// >>> logic/dram_address_mux.sv
// Row or column selection onto a shared memory address port
`timescale 1ns/100ps
`default_nettype none

module dram_address_mux #(
  parameter int ADDR_W = 12,
  parameter int ROW_W  = 8,
  parameter int COL_W  = 4
) (
  // Address layout of the memory
  input  wire logic              muxEn,
  input  wire logic              hasRow,
  input  wire logic              hasCol,
  input  wire logic              selColumn,
  // Address sources
  input  wire logic [ROW_W-1:0]  rowAddr,
  input  wire logic [COL_W-1:0]  colAddr,
  input  wire logic [ADDR_W-1:0] fullAddr,
  // Address toward the memory
  output logic      [ADDR_W-1:0] memAddr
);

  always_comb begin
    if (!muxEn || !hasRow || !hasCol) begin
      memAddr = fullAddr; // RULE_12 RULE_14
    end else if (selColumn) begin
      memAddr = ADDR_W'(colAddr); // RULE_10
    end else begin
      memAddr = ADDR_W'(rowAddr); // RULE_11
    end
  end

endmodule
`default_nettype wire

// >>> logic/bist_dram_cycle_signals.sv
// Per-cycle DRAM strobe and concurrent-read generator with APB program registers
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// [RULE_01] All controlled outputs change only at BIST clock edges, once per step.
// [RULE_02] Each signal holds its last programmed level; auto keeps it.
// [RULE_03] Activate follows on/off; auto in first cycle means deasserted.
// [RULE_04] Precharge follows on/off; first cycle default off, later auto holds.
// [RULE_05] Column strobe follows on/off; first cycle inactive, later auto holds.
// [RULE_06] Row strobe follows on/off; first cycle inactive, later auto holds.
// [RULE_07] Refresh follows on/off; first cycle inactive, later auto holds.
// [RULE_08] Active electrical level of each strobe comes from configured polarity.
// [RULE_09] A strobe acts only if the memory has that port function.
// [RULE_10] Multiplexed address with column chosen drives column bits.
// [RULE_11] Multiplexed address with row chosen drives row bits.
// [RULE_12] Non-multiplexed memories get the full address, choice ignored.
// [RULE_13] Address choice defaults to row first cycle; auto holds later.
// [RULE_14] Choice ignored when the layout lacks row or column bits.
// [RULE_15] Concurrent read follows on/off, default off, never for 1RW or ROM.
// [RULE_16] Concurrent read is fixed per operation program, not per instruction.
// [RULE_17] Concurrent read may be on in any cycles, reads or writes alike.
// [RULE_18] Concurrent read data is not compared unless enabled.
// [RULE_19] Only the logical port chosen for the test port is compared.
// [RULE_20] Compare only when the algorithm does not read the test port.
// [RULE_21] Compare needs main select and read not both on.
// [RULE_22] Strobe carries expect data; same cycle async, next cycle sync.
// [RULE_23] Per-cycle program sits in registers loaded before the operation.
module bist_dram_cycle_signals #(
  parameter int NCYC   = 8,
  parameter int ADDR_W = 12,
  parameter int ROW_W  = 8,
  parameter int COL_W  = 4,
  parameter int DATA_W = 16,
  parameter int IDXW   = $clog2(NCYC)
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // APB slave
  input  wire logic [bist_dram_pkg::APB_AW-1:0]  paddr,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [31:0]                       pwdata,
  output logic                                   pready,
  output logic      [31:0]                       prdata,
  output logic                                   pslverr,
  // Operation sequencer
  input  wire logic                              stepValid,
  input  wire logic                              firstCycle,
  input  wire logic                              lastCycle,
  input  wire logic [IDXW-1:0]                   cycleIdx,
  input  wire logic                              mainSelect,
  input  wire logic                              mainReadEnable,
  input  wire logic                              algoReadOnTestPort,
  input  wire logic [ROW_W-1:0]                  rowAddr,
  input  wire logic [COL_W-1:0]                  colAddr,
  input  wire logic [ADDR_W-1:0]                 fullAddr,
  input  wire logic [DATA_W-1:0]                 expectData,
  // Memory under test
  output logic                                   activateOut,
  output logic                                   prechargeOut,
  output logic                                   casOut,
  output logic                                   rasOut,
  output logic                                   refreshOut,
  output logic      [ADDR_W-1:0]                 memAddress,
  output logic                                   concReadEnable,
  // Comparator
  output logic                                   compareStrobe,
  output logic      [DATA_W-1:0]                 compareExpect,
  output logic                                   comparePortSel
);
  import bist_dram_pkg::*;

  typedef struct packed {
    op_state_t                     state;
    logic [31:0]                   ctrl;
    logic [NCYC-1:0][CODE_W-1:0]   prog;
    logic [NSIG-1:0]               held;
    logic                          pready;
    logic [31:0]                   prdata;
    logic                          pslverr;
    logic [NDRAM-1:0]              pins;
    logic [ADDR_W-1:0]             addr;
    logic                          concRd;
    logic                          pend;
    logic [DATA_W-1:0]             pendExp;
    logic                          strobe;
    logic [DATA_W-1:0]             cmpExp;
    logic                          portSel;
  } gen_state_t;

  gen_state_t         s_r;
  gen_state_t         s_nxt;
  logic [1:0]         rstPipe_r;
  logic               rstSync_n;
  logic [CODE_W-1:0]  curCodes;
  logic [NSIG-1:0]    nextHeld;
  logic [ADDR_W-1:0]  muxAddr;
  logic               accWin;
  logic               done;
  logic               wrOk;
  logic               progHit;
  logic [IDXW-1:0]    progIdx;
  logic               eligible;
  logic [NDRAM-1:0]   pol;
  logic [NDRAM-1:0]   present;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_r <= 2'b00;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe_r[1];

  assign pol     = s_r.ctrl[POL_LSB +: NDRAM];
  assign present = s_r.ctrl[PRESENT_LSB +: NDRAM];

  // Out-of-range cycle indices read as all auto
  assign curCodes = (int'(cycleIdx) < NCYC) ? s_r.prog[cycleIdx] : '0; // RULE_23

  cycle_code_resolver #(
    .NSIG (NSIG)
  ) uResolver (
    .codes      (curCodes),
    .held       (s_r.held),
    .firstCycle (firstCycle),
    .nextHeld   (nextHeld)
  );

  dram_address_mux #(
    .ADDR_W (ADDR_W),
    .ROW_W  (ROW_W),
    .COL_W  (COL_W)
  ) uAddrMux (
    .muxEn     (s_r.ctrl[MUX_BIT]),
    .hasRow    (s_r.ctrl[HASROW_BIT]),
    .hasCol    (s_r.ctrl[HASCOL_BIT]),
    .selColumn (nextHeld[SIG_ASEL]),
    .rowAddr   (rowAddr),
    .colAddr   (colAddr),
    .fullAddr  (fullAddr),
    .memAddr   (muxAddr)
  );

  // APB phases: answer computed one cycle into access, write lands at completion
  assign accWin  = psel && penable && !s_r.pready;
  assign done    = psel && penable && s_r.pready;
  assign progHit = (paddr >= PROG_BASE) && (int'(paddr) < int'(PROG_BASE) + 4 * NCYC)
                   && (paddr[1:0] == 2'b00);
  assign progIdx = IDXW'((paddr - PROG_BASE) >> 2);
  // Program is frozen while an operation runs
  assign wrOk    = done && pwrite && !s_r.pslverr && (s_r.state == ST_IDLE)
                   && !stepValid; // RULE_16

  assign eligible = stepValid && s_r.ctrl[CMPEN_BIT] && s_r.ctrl[CONCCAP_BIT] // RULE_18
                    && nextHeld[SIG_CRD]
                    && !algoReadOnTestPort // RULE_20
                    && !(mainSelect && mainReadEnable); // RULE_21

  always_comb begin
    s_nxt        = s_r;
    s_nxt.pready = accWin;
    if (accWin) begin
      s_nxt.prdata  = 32'h0000_0000;
      s_nxt.pslverr = 1'b0;
      if (paddr == CTRL_OFFS) begin
        s_nxt.prdata = s_r.ctrl;
      end else if (paddr == STATUS_OFFS) begin
        s_nxt.prdata[STAT_HELD_LSB +: NSIG] = s_r.held;
        s_nxt.prdata[STAT_RUN_BIT]          = (s_r.state == ST_RUN);
      end else if (progHit) begin
        s_nxt.prdata = 32'(s_r.prog[progIdx]);
      end else begin
        s_nxt.pslverr = 1'b1;
      end
      if (pwrite && (paddr == STATUS_OFFS || s_r.state == ST_RUN || stepValid)) begin
        s_nxt.pslverr = 1'b1;
      end
    end
    if (wrOk) begin
      if (paddr == CTRL_OFFS) begin
        s_nxt.ctrl = pwdata;
      end else if (progHit) begin
        s_nxt.prog[progIdx] = pwdata[CODE_W-1:0]; // RULE_23
      end
    end

    // One setting per step; the memory controls hold between steps
    if (stepValid) begin // RULE_01
      s_nxt.held = nextHeld; // RULE_02
      for (int i = 0; i < NDRAM; i++) begin
        // Absent port functions sit at their inactive level
        s_nxt.pins[i] = (present[i] && nextHeld[i]) ? pol[i] : !pol[i]; // RULE_08 RULE_09
      end
      s_nxt.addr   = muxAddr; // RULE_10
      s_nxt.concRd = s_r.ctrl[CONCCAP_BIT] && nextHeld[SIG_CRD]; // RULE_15
    end

    // Sync read ports see the strobe one cycle after the concurrent read
    s_nxt.strobe  = s_r.ctrl[SYNCRD_BIT] ? s_r.pend : eligible; // RULE_22
    s_nxt.cmpExp  = s_r.ctrl[SYNCRD_BIT] ? s_r.pendExp : expectData;
    s_nxt.pend    = eligible && s_r.ctrl[SYNCRD_BIT];
    s_nxt.pendExp = expectData;
    s_nxt.portSel = s_r.ctrl[PORTSEL_BIT]; // RULE_19

    unique case (s_r.state)
      ST_IDLE: begin
        if (stepValid && firstCycle && !lastCycle) begin
          s_nxt.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stepValid && lastCycle) begin
          s_nxt.state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s_r      <= '0;
      s_r.ctrl <= CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pready         = s_r.pready;
  assign prdata         = s_r.prdata;
  assign pslverr        = s_r.pslverr;
  assign activateOut    = s_r.pins[SIG_ACT]; // RULE_03
  assign prechargeOut   = s_r.pins[SIG_PRE]; // RULE_04
  assign casOut         = s_r.pins[SIG_CAS]; // RULE_05
  assign rasOut         = s_r.pins[SIG_RAS]; // RULE_06
  assign refreshOut     = s_r.pins[SIG_REF]; // RULE_07
  assign memAddress     = s_r.addr;
  assign concReadEnable = s_r.concRd; // RULE_17
  assign compareStrobe  = s_r.strobe;
  assign compareExpect  = s_r.cmpExp;
  assign comparePortSel = s_r.portSel;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_n);

  logic [1:0] codeAct;
  logic [1:0] codePre;
  logic [1:0] codeCas;
  logic [1:0] codeRas;
  logic [1:0] codeRef;
  logic [1:0] codeAsel;
  logic       fullMux;
  assign codeAct  = curCodes[2*SIG_ACT +: 2];
  assign codePre  = curCodes[2*SIG_PRE +: 2];
  assign codeCas  = curCodes[2*SIG_CAS +: 2];
  assign codeRas  = curCodes[2*SIG_RAS +: 2];
  assign codeRef  = curCodes[2*SIG_REF +: 2];
  assign codeAsel = curCodes[2*SIG_ASEL +: 2];
  assign fullMux  = s_r.ctrl[MUX_BIT] && s_r.ctrl[HASROW_BIT] && s_r.ctrl[HASCOL_BIT];

  sequence s_syncEligible;
    eligible && s_r.ctrl[SYNCRD_BIT];
  endsequence

  sequence s_strobeNext;
    !compareStrobe ##1 compareStrobe && compareExpect == $past(expectData, 2);
  endsequence

  property p_noStepNoChange;
    !stepValid |=> $stable({activateOut, prechargeOut, casOut, rasOut, refreshOut,
                            memAddress, concReadEnable});
  endproperty
  a_noStepNoChange: assert property (p_noStepNoChange) // RULE_01
    else $error("Memory controls changed without a step");

  property p_autoHolds;
    stepValid && !firstCycle && s_r.state == ST_RUN && codeCas == CODE_AUTO
      && codeRas == CODE_AUTO |=> $stable(casOut) && $stable(rasOut);
  endproperty
  a_autoHolds: assert property (p_autoHolds) // RULE_02
    else $error("Auto cycle did not hold the strobe levels");

  property p_firstActOff;
    stepValid && firstCycle && codeAct != CODE_ON |=> activateOut == !$past(pol[SIG_ACT]);
  endproperty
  a_firstActOff: assert property (p_firstActOff) // RULE_03
    else $error("Activate not inactive in first cycle");

  property p_preOn;
    stepValid && codePre == CODE_ON && present[SIG_PRE]
      |=> prechargeOut == $past(pol[SIG_PRE]);
  endproperty
  a_preOn: assert property (p_preOn) // RULE_04
    else $error("Precharge not at its active level");

  property p_refAbsent;
    stepValid && !present[SIG_REF] |=> refreshOut == !$past(pol[SIG_REF]);
  endproperty
  a_refAbsent: assert property (p_refAbsent) // RULE_09
    else $error("Refresh moved without its port function");

  property p_colAddr;
    stepValid && fullMux && codeAsel == CODE_ON |=> memAddress == ADDR_W'($past(colAddr));
  endproperty
  a_colAddr: assert property (p_colAddr) // RULE_10
    else $error("Column address not driven");

  property p_rowFirst;
    stepValid && firstCycle && fullMux && codeAsel != CODE_ON
      |=> memAddress == ADDR_W'($past(rowAddr));
  endproperty
  a_rowFirst: assert property (p_rowFirst) // RULE_13
    else $error("Row not selected in first cycle");

  property p_noMux;
    stepValid && !fullMux |=> memAddress == $past(fullAddr);
  endproperty
  a_noMux: assert property (p_noMux) // RULE_12
    else $error("Full address altered without multiplexing");

  property p_noConcRead;
    stepValid && !s_r.ctrl[CONCCAP_BIT] |=> !concReadEnable;
  endproperty
  a_noConcRead: assert property (p_noConcRead) // RULE_15
    else $error("Concurrent read on a memory without it");

  property p_noCompare;
    stepValid && !s_r.pend && (!s_r.ctrl[CMPEN_BIT] || algoReadOnTestPort)
      |=> !compareStrobe;
  endproperty
  a_noCompare: assert property (p_noCompare) // RULE_20
    else $error("Compare strobe without eligibility");

  property p_syncStrobe;
    !eligible ##1 s_syncEligible ##1 s_r.ctrl[SYNCRD_BIT] |-> s_strobeNext;
  endproperty
  a_syncStrobe: assert property (p_syncStrobe) // RULE_22
    else $error("Synchronous compare strobe misplaced");

  property p_portSel;
    compareStrobe |-> comparePortSel == $past(s_r.ctrl[PORTSEL_BIT]);
  endproperty
  a_portSel: assert property (p_portSel) // RULE_19
    else $error("Compare on a port other than the test port");

endmodule
`default_nettype wire

// >>> verification/dram_mem_model.sv
// Behavioural model of the DRAM-style memory under test
`timescale 1ns/100ps
`default_nettype none

module dram_mem_model (
  // Clock and active level of the strobes
  input  wire logic        clk,
  input  wire logic        activeLevel,
  // Controls from the generator
  input  wire logic        activateIn,
  input  wire logic        prechargeIn,
  input  wire logic        concReadIn,
  input  wire logic [11:0] addrIn,
  // Observed bank state
  output logic             rowOpen,
  output logic      [11:0] openRow,
  output logic      [7:0]  concReads
);
  initial begin
    rowOpen = 1'b0;
    openRow = '0;
    concReads = '0;
  end

  // Precharge wins over activate in the same cycle, as a real bank would
  always @(posedge clk) begin
    if (prechargeIn === activeLevel) begin
      rowOpen <= 1'b0;
    end else if (activateIn === activeLevel) begin
      rowOpen <= 1'b1;
      openRow <= addrIn;
    end
    if (concReadIn === 1'b1) begin
      concReads <= concReads + 8'h01;
    end
  end
endmodule

`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench of the DRAM and concurrent-port cycle signal generator
`timescale 1ns/100ps
`default_nettype none

module tb;
  import bist_dram_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  paddr = '0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic        stepValid = 1'b0;
  logic        firstCycle = 1'b0;
  logic        lastCycle = 1'b0;
  logic [2:0]  cycleIdx = '0;
  logic        mainSelect = 1'b0;
  logic        mainReadEnable = 1'b0;
  logic        algoReadOnTestPort = 1'b0;
  logic [7:0]  rowAddr = 8'hA5;
  logic [3:0]  colAddr = 4'h6;
  logic [11:0] fullAddr = 12'h9C3;
  logic [15:0] expectData = 16'hBEEF;
  logic        pready, pslverr, compareStrobe, comparePortSel, concReadEnable;
  logic        activateOut, prechargeOut, casOut, rasOut, refreshOut;
  logic [31:0] prdata;
  logic [11:0] memAddress;
  logic [15:0] compareExpect;
  logic        rowOpen;
  logic [11:0] openRow;
  logic [7:0]  concReads;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  wire logic [5:0] lv = {concReadEnable, refreshOut, rasOut, casOut, prechargeOut, activateOut};

  always #10 clk = ~clk;

  bist_dram_cycle_signals bist_dram_cycle_signals_inst (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .stepValid(stepValid), .firstCycle(firstCycle),
    .lastCycle(lastCycle), .cycleIdx(cycleIdx), .mainSelect(mainSelect),
    .mainReadEnable(mainReadEnable), .algoReadOnTestPort(algoReadOnTestPort),
    .rowAddr(rowAddr), .colAddr(colAddr), .fullAddr(fullAddr),
    .expectData(expectData), .activateOut(activateOut), .prechargeOut(prechargeOut),
    .casOut(casOut), .rasOut(rasOut), .refreshOut(refreshOut),
    .memAddress(memAddress), .concReadEnable(concReadEnable),
    .compareStrobe(compareStrobe), .compareExpect(compareExpect),
    .comparePortSel(comparePortSel));

  dram_mem_model dram_mem_model_inst (
    .clk(clk), .activeLevel(1'b1), .activateIn(activateOut),
    .prechargeIn(prechargeOut), .concReadIn(concReadEnable), .addrIn(memAddress),
    .rowOpen(rowOpen), .openRow(openRow), .concReads(concReads));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic eexp);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    check(e, eexp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(e, eexp);
    if (!eexp) check(r, exp);
  endtask

  task automatic step(input logic f, input logic l, input logic [2:0] i,
                      input logic ms, input logic mr, input logic ar);
    @(posedge clk);
    stepValid <= 1'b1;
    firstCycle <= f;
    lastCycle <= l;
    cycleIdx <= i;
    mainSelect <= ms;
    mainReadEnable <= mr;
    algoReadOnTestPort <= ar;
    @(posedge clk);
    stepValid <= 1'b0;
    firstCycle <= 1'b0;
    lastCycle <= 1'b0;
    @(negedge clk);
  endtask

  // Strobe offset counted in negedges after the step; 9 means none seen
  task automatic cmp_try(input logic [31:0] c, input logic ms, input logic mr,
                         input logic ar, input int k);
    int seen;
    seen = 9;
    wr(CTRL_OFFS, c, 1'b0);
    step(1'b1, 1'b1, 3'd0, ms, mr, ar);
    for (int j = 0; j < 4; j++) begin
      if (compareStrobe === 1'b1 && seen == 9) begin
        seen = j;
        check(compareExpect, expectData);
      end
      @(negedge clk);
    end
    check(seen, k);
  endtask

  initial begin
    #200_000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(lv, 6'h00);
    rd(CTRL_OFFS, CTRL_RESET, 1'b0);
    rd(STATUS_OFFS, 32'h0000_0000, 1'b0);
    rd(8'h30, 32'h0000_0000, 1'b1);
    wr(STATUS_OFFS, 32'h0000_00FF, 1'b1);
    wr(PROG_BASE, 32'h0000_2AAA, 1'b0);
    wr(PROG_BASE + 8'h04, 32'h0000_0000, 1'b0);
    wr(PROG_BASE + 8'h08, 32'h0000_1555, 1'b0);
    rd(PROG_BASE, 32'h0000_2AAA, 1'b0);
    wr(CTRL_OFFS, 32'h000F_1F1F, 1'b0);
    $display("registers done");
    step(1'b1, 1'b0, 3'd0, 1'b0, 1'b0, 1'b0);
    check(lv, 6'h3F);
    check(memAddress[3:0], colAddr);
    rd(STATUS_OFFS, 32'h0000_017F, 1'b0);
    wr(CTRL_OFFS, 32'h0000_0000, 1'b1);
    step(1'b0, 1'b1, 3'd1, 1'b0, 1'b0, 1'b0);
    check(lv, 6'h3F);
    check(memAddress[3:0], colAddr);
    step(1'b1, 1'b0, 3'd1, 1'b0, 1'b0, 1'b0);
    check(lv, 6'h00);
    check(memAddress[7:0], rowAddr);
    step(1'b0, 1'b0, 3'd0, 1'b1, 1'b1, 1'b0);
    check(lv, 6'h3F);
    step(1'b0, 1'b1, 3'd2, 1'b0, 1'b0, 1'b0);
    check(lv, 6'h00);
    check(memAddress[7:0], rowAddr);
    $display("sequence done");
    wr(CTRL_OFFS, 32'h000F_1E00, 1'b0);
    step(1'b1, 1'b1, 3'd0, 1'b0, 1'b0, 1'b0);
    check(lv, 6'h21);
    wr(CTRL_OFFS, 32'h000E_1F1F, 1'b0);
    check({rowOpen, openRow}, {1'b1, 8'h00, colAddr});
    step(1'b1, 1'b1, 3'd0, 1'b0, 1'b0, 1'b0);
    check(memAddress, fullAddr);
    wr(CTRL_OFFS, 32'h000B_1F1F, 1'b0);
    step(1'b1, 1'b1, 3'd0, 1'b0, 1'b0, 1'b0);
    check(memAddress, fullAddr);
    wr(CTRL_OFFS, 32'h0007_1F1F, 1'b0);
    step(1'b1, 1'b1, 3'd0, 1'b0, 1'b0, 1'b0);
    check(lv, 6'h1F);
    $display("configuration done");
    cmp_try(32'h001F_1F1F, 1'b1, 1'b0, 1'b0, 0);
    cmp_try(32'h001F_1F1F, 1'b0, 1'b1, 1'b0, 0);
    cmp_try(32'h001F_1F1F, 1'b0, 1'b0, 1'b0, 0);
    cmp_try(32'h001F_1F1F, 1'b1, 1'b1, 1'b0, 9);
    cmp_try(32'h001F_1F1F, 1'b0, 1'b0, 1'b1, 9);
    cmp_try(32'h000F_1F1F, 1'b0, 1'b0, 1'b0, 9);
    cmp_try(32'h003F_1F1F, 1'b0, 1'b0, 1'b0, 1);
    cmp_try(32'h011F_1F1F, 1'b0, 1'b0, 1'b0, 0);
    check(comparePortSel, 1'b1);
    $display("compare done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
